//--- design/flash_lock_and_write_guard.sv
// flash lock and write guard: key, enables, page locks, error reset
// assumes accesses are one-cycle strobes from the cpu and the debug port
`timescale 1ns/1ps
`include "flash_guard_defines.svh"
module flash_lock_and_write_guard #(
	parameter int ADDR_W = 15,
	parameter logic [ADDR_W-1:0] LOCK_ADDR = 15'h7fff
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// special register port
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_psc_rdata,
	output logic [7:0] o_rst_rdata,
	// supply monitor state
	input wire logic i_vmon_en,
	input wire logic i_vmon_rst_en,
	// firmware flash access
	input wire logic i_cpu_req,
	input wire logic [1:0] i_cpu_op,
	input wire logic [ADDR_W-1:0] i_cpu_addr,
	input wire logic [ADDR_W-1:0] i_cpu_pc,
	input wire logic [7:0] i_cpu_wdata,
	// debug flash access
	input wire logic i_dbg_req,
	input wire logic [1:0] i_dbg_op,
	input wire logic [ADDR_W-1:0] i_dbg_addr,
	input wire logic [7:0] i_dbg_wdata,
	input wire logic i_dbg_device_erase,
	// flash array side
	output logic o_fl_go,
	output logic [1:0] o_fl_op,
	output logic [ADDR_W-1:0] o_fl_addr,
	output logic [7:0] o_fl_wdata,
	output logic o_fl_mass_erase,
	input wire logic [7:0] i_fl_lock_byte,
	// system
	output logic o_flash_error_device_reset,
	output logic o_irq_hold
);
	// register state
	logic store_write_enable_r, store_erase_enable_r;
	flash_guard_pkg::key_state_t key_r;
	logic [7:0] lock_active_r;
	logic flash_error_flag_r, por_flag_r, reset_pend_r, load_lock_r;
	logic [7:0] busy_cnt_r;

	// page classification and access decisions
	logic cpu_lock, cpu_lpage, pc_lock, pc_lpage, dbg_lock, dbg_lpage;
	logic cpu_fault, cpu_ok, dbg_ok, cpu_mod, lock_byte_hit, dbg_lock_hit;

	// classify firmware target, firmware origin and debug target
	flash_page_check #(.ADDR_W(ADDR_W), .LOCK_ADDR(LOCK_ADDR)) u_cpu_chk (
		.i_addr(i_cpu_addr),
		.i_lock(lock_active_r),
		.o_locked(cpu_lock),
		.o_lock_page(cpu_lpage)
	);
	flash_page_check #(.ADDR_W(ADDR_W), .LOCK_ADDR(LOCK_ADDR)) u_pc_chk (
		.i_addr(i_cpu_pc),
		.i_lock(lock_active_r),
		.o_locked(pc_lock),
		.o_lock_page(pc_lpage)
	);
	flash_page_check #(.ADDR_W(ADDR_W), .LOCK_ADDR(LOCK_ADDR)) u_dbg_chk (
		.i_addr(i_dbg_addr),
		.i_lock(lock_active_r),
		.o_locked(dbg_lock),
		.o_lock_page(dbg_lpage)
	);

	// firmware access legality
	always_comb begin
		cpu_mod = (i_cpu_op != flash_guard_pkg::OP_READ);
		lock_byte_hit = (i_cpu_addr == LOCK_ADDR);
		cpu_fault = 1'b0;
		if (cpu_lock && !pc_lock)
			cpu_fault = 1'b1;
		if (cpu_mod) begin
			if (!store_write_enable_r)
				cpu_fault = 1'b1;
			if (i_cpu_op == flash_guard_pkg::OP_ERASE && !store_erase_enable_r)
				cpu_fault = 1'b1;
			if (key_r != flash_guard_pkg::KEY_OPEN)
				cpu_fault = 1'b1;
			if (!(i_vmon_en && i_vmon_rst_en))
				cpu_fault = 1'b1;
			if (i_cpu_op == flash_guard_pkg::OP_ERASE && cpu_lpage)
				cpu_fault = 1'b1;
			if (lock_byte_hit && i_fl_lock_byte != `FG_LOCK_RESET)
				cpu_fault = 1'b1;
		end
		// the unused operation code is always a fault
		if (i_cpu_op == 2'b11)
			cpu_fault = 1'b1;
		cpu_ok = i_cpu_req && !cpu_fault && !reset_pend_r;
		dbg_lock_hit = (i_dbg_addr == LOCK_ADDR) && (i_fl_lock_byte != `FG_LOCK_RESET);
		// debug refusal is silent
		dbg_ok = i_dbg_req && !dbg_lock && !(i_dbg_op == 2'b11)
			&& !(i_dbg_op != flash_guard_pkg::OP_READ && dbg_lock_hit)
			&& !(i_dbg_op == flash_guard_pkg::OP_ERASE && dbg_lpage && dbg_lock);
	end

	// program store control register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			store_write_enable_r <= 1'b0;
			store_erase_enable_r <= 1'b0;
		end else if (i_sfr_wr && i_sfr_addr == `FG_PSC_ADDR) begin
			store_write_enable_r <= i_sfr_wdata[`FG_PSC_WE_BIT];
			store_erase_enable_r <= i_sfr_wdata[`FG_PSC_EE_BIT];
		end
	end

	// unlock key sequence, consumed by one modify attempt
	// a refused modify still consumes the key, so a retry must unlock again
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			key_r <= flash_guard_pkg::KEY_IDLE;
		end else if (i_cpu_req && cpu_mod) begin
			key_r <= flash_guard_pkg::KEY_IDLE;
		end else if (i_sfr_wr && i_sfr_addr == `FG_KEY_ADDR) begin
			case (key_r)
				flash_guard_pkg::KEY_IDLE: key_r <= (i_sfr_wdata == `FG_KEY_FIRST) ?
					flash_guard_pkg::KEY_FIRST : flash_guard_pkg::KEY_IDLE;
				flash_guard_pkg::KEY_FIRST: key_r <= (i_sfr_wdata == `FG_KEY_SECOND) ?
					flash_guard_pkg::KEY_OPEN : flash_guard_pkg::KEY_IDLE;
				default: key_r <= flash_guard_pkg::KEY_IDLE;
			endcase
		end
	end

	// lock setting loaded only at reset release
	// a firmware write to the lock byte only reaches the array, not this copy
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			load_lock_r <= 1'b1;
			lock_active_r <= 8'h00;
		end else if (load_lock_r) begin
			load_lock_r <= 1'b0;
			lock_active_r <= i_fl_lock_byte;
		end
	end

	// error reset request; flags below survive device reset
	// the pending bit keeps later firmware requests off the array until reset
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			reset_pend_r <= 1'b0;
			o_flash_error_device_reset <= 1'b0;
		end else begin
			reset_pend_r <= reset_pend_r | (i_cpu_req && cpu_fault);
			o_flash_error_device_reset <= reset_pend_r | (i_cpu_req && cpu_fault);
		end
	end

	// flash error flag; a set wins over a clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_cpu_req && cpu_fault && !i_rst) begin
			flash_error_flag_r <= 1'b1;
		end else if (i_sfr_wr && i_sfr_addr == `FG_RST_ADDR && !i_rst) begin
			flash_error_flag_r <= 1'b0;
		end
	end

	// power-on flag: cleared by an error reset, written directly by software
	always_ff @(posedge i_core_clk) begin
		if (i_cpu_req && cpu_fault && !i_rst) begin
			por_flag_r <= 1'b0;
		end else if (i_sfr_wr && i_sfr_addr == `FG_RST_ADDR && !i_rst) begin
			por_flag_r <= i_sfr_wdata[`FG_RST_POR_BIT];
		end
	end

	// register read images
	// flags that were never written read as zero
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_psc_rdata <= 8'h00;
			o_rst_rdata <= 8'h00;
		end else begin
			o_psc_rdata <= {6'h00, store_erase_enable_r, store_write_enable_r};
			o_rst_rdata <= {1'b0, flash_error_flag_r === 1'b1, 4'h0,
				por_flag_r === 1'b1, 1'b0};
		end
	end

	// issue to the array: firmware, then debug; a debug mass erase goes out alongside a firmware access
	// a device erase takes the debug slot, so a debug request beside it is dropped
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_fl_go <= 1'b0;
			o_fl_op <= flash_guard_pkg::OP_READ;
			o_fl_addr <= '0;
			o_fl_wdata <= 8'h00;
			o_fl_mass_erase <= 1'b0;
		end else begin
			o_fl_mass_erase <= i_dbg_device_erase;
			o_fl_go <= cpu_ok | (dbg_ok & !i_dbg_device_erase);
			o_fl_op <= cpu_ok ? i_cpu_op : i_dbg_op;
			o_fl_addr <= cpu_ok ? i_cpu_addr : i_dbg_addr;
			o_fl_wdata <= cpu_ok ? i_cpu_wdata : i_dbg_wdata;
		end
	end

	// interrupt hold while a modify runs
	// the hold lasts the modelled operation time in all, the accepted cycle included
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			busy_cnt_r <= 8'h00;
			o_irq_hold <= 1'b0;
		end else begin
			if (cpu_ok && cpu_mod)
				busy_cnt_r <= `FG_OP_CYCLES;
			else if (busy_cnt_r != 8'h00)
				busy_cnt_r <= busy_cnt_r - 8'h01;
			o_irq_hold <= (cpu_ok && cpu_mod) || busy_cnt_r > 8'h01;
		end
	end
endmodule : flash_lock_and_write_guard

//--- design/flash_page_check.sv
// page classification of a flash address against the lock byte
// assumes 512-byte pages and a lock byte at the last byte of user space
`timescale 1ns/1ps
`include "flash_guard_defines.svh"
module flash_page_check #(
	parameter int ADDR_W = 15,
	parameter logic [ADDR_W-1:0] LOCK_ADDR = 15'h7fff
) (
	// address and active lock
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_lock,
	// classification
	output logic o_locked,
	output logic o_lock_page
);
	localparam int PW = ADDR_W - `FG_PAGE_BITS;
	logic [7:0] n_locked;
	logic [PW-1:0] page;
	logic any_locked;
	// ones complement gives the count of locked pages from page zero
	assign n_locked = ~i_lock;
	assign any_locked = (i_lock != `FG_LOCK_RESET);
	assign page = i_addr[ADDR_W-1:`FG_PAGE_BITS];
	assign o_lock_page = (page == LOCK_ADDR[ADDR_W-1:`FG_PAGE_BITS]);
	// lock byte page follows any lock, other pages by count; both sides widened on purpose
	assign o_locked = (o_lock_page & any_locked)
		| (32'(n_locked) > 32'(page));
endmodule : flash_page_check

//--- include/flash_guard_defines.svh
// constants for the flash lock and write guard
// assumes an 8-bit special-register port and 512-byte pages
// Operation
// - debug device erase clears every page, lock byte page too, removing locks.
// - forbidden firmware access causes flash-error reset; flash error flag reads one.
// - forbidden debug operations are discarded without reset or flash change.
// - any locked page also locks the page holding the lock byte.
// - programmed lock byte cannot change except by debug device erase; the code passes a debug erase elsewhere in its page until next reset.
// - firmware lock byte write takes effect only after next device reset.
// - firmware modify needs supply monitor and its reset enable, else reset.
// - store write enable is bit zero of program store control.
// - interrupts arriving during flash operation stay pending until operation ends.
// - modify needs write enable; erase needs write and erase enable.
// - key register must get first then second unlock code before each operation.
// - locked page count from page zero equals ones-complement of lock byte.
// - locked pages refused on debug; reset from unlocked code; locked code allowed.
`ifndef FLASH_GUARD_DEFINES_SVH
`define FLASH_GUARD_DEFINES_SVH
`define FG_PSC_ADDR 8'h8f
`define FG_KEY_ADDR 8'hb7
`define FG_RST_ADDR 8'hef
`define FG_PSC_WE_BIT 0
`define FG_PSC_EE_BIT 1
`define FG_RST_POR_BIT 1
`define FG_RST_FERR_BIT 6
`define FG_KEY_FIRST 8'ha5
`define FG_KEY_SECOND 8'hf1
`define FG_LOCK_RESET 8'hff
`define FG_PAGE_BITS 9
`define FG_OP_CYCLES 8'h0a
`endif

//--- include/flash_guard_pkg.sv
// types for the flash lock and write guard
// assumes the defines header is compiled alongside
package flash_guard_pkg;
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_FIRST = 2'b01,
		KEY_OPEN = 2'b10
	} key_state_t;
	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_WRITE = 2'b01,
		OP_ERASE = 2'b10
	} access_t;
endpackage : flash_guard_pkg

//--- testbench/flash_array_model.sv
// flash array stand-in that keeps only the lock byte
// assumes guard outputs are registered on i_core_clk
`timescale 1ns/1ps
module flash_array_model (
	// guard side
	input wire logic i_core_clk,
	input wire logic i_go,
	input wire logic [1:0] i_op,
	input wire logic [14:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_mass,
	// lock byte contents
	output logic [7:0] o_lock_byte = 8'hff
);
	// writes only clear bits; mass erase sets all bits again
	always @(posedge i_core_clk) begin
		if (i_mass) o_lock_byte <= 8'hff;
		else if (i_go && i_op == 2'h1 && i_addr == 15'h7fff) o_lock_byte <= o_lock_byte & i_wdata;
	end
endmodule : flash_array_model

//--- testbench/flash_guard_asserts.sv
// port checker for the flash guard
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module flash_guard_asserts (
	// watched ports
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_cpu_req,
	input wire logic [1:0] i_cpu_op,
	input wire logic i_dbg_req,
	input wire logic i_dbg_device_erase,
	input wire logic i_vmon_en,
	input wire logic i_vmon_rst_en,
	input wire logic [7:0] o_psc_rdata,
	input wire logic [7:0] o_rst_rdata,
	input wire logic o_fl_go,
	input wire logic [1:0] o_fl_op,
	input wire logic o_fl_mass_erase,
	input wire logic o_flash_error_device_reset,
	input wire logic o_irq_hold
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// accepted firmware write or erase
	sequence cpu_mod_s;
		o_fl_go && o_fl_op != 2'h0 && $past(i_cpu_req);
	endsequence
	err_hold_a: assert property (o_flash_error_device_reset |=> o_flash_error_device_reset)
		else $error("error reset dropped");
	err_src_a: assert property ($rose(o_flash_error_device_reset) |-> $past(i_cpu_req))
		else $error("error reset without firmware cause");
	vmon_a: assert property (i_cpu_req && i_cpu_op != 2'h0 && !(i_vmon_en && i_vmon_rst_en)
		|=> o_flash_error_device_reset) else $error("modify without monitor");
	err_flag_a: assert property (o_flash_error_device_reset |=> o_rst_rdata[6])
		else $error("flash error flag low");
	mod_en_a: assert property (cpu_mod_s |-> $past(o_psc_rdata[0])
		&& ($past(o_psc_rdata[1]) || o_fl_op != 2'h2)) else $error("modify without enables");
	mass_a: assert property (i_dbg_device_erase |=> o_fl_mass_erase)
		else $error("device erase lost");
	irq_hold_a: assert property (cpu_mod_s |-> o_irq_hold [*8])
		else $error("interrupt hold short");
	go_cause_a: assert property (o_fl_go |-> $past(i_cpu_req || i_dbg_req))
		else $error("flash strobe without request");
endmodule : flash_guard_asserts
bind flash_lock_and_write_guard flash_guard_asserts chk_u (.i_core_clk, .i_rst, .i_cpu_req,
	.i_cpu_op, .i_dbg_req, .i_dbg_device_erase, .i_vmon_en, .i_vmon_rst_en, .o_psc_rdata,
	.o_rst_rdata, .o_fl_go, .o_fl_op, .o_fl_mass_erase, .o_flash_error_device_reset, .o_irq_hold);

//--- testbench/test_flash_lock_and_write_guard.sv
// self-checking bench for the flash guard against a bench model
// assumes the array model supplies the lock byte
`timescale 1ns/1ps
module test_flash_lock_and_write_guard;
	logic clk = 0, rst = 1, sfr_wr = 0, cpu_req = 0, dbg_req = 0, dev_erase = 0, vmon = 1;
	logic vmon_rst = 1;
	logic go, mass, err, irq;
	logic [1:0] op_c = 0, op_d = 0, fl_op;
	logic [7:0] sfr_a = 0, sfr_d = 0, wd_c = 0, wd_d = 0, psc, rsr, fl_wd, lock_b;
	logic [7:0] psc_m = 0, lock_m = 8'hff, lock_act = 8'hff;
	logic [14:0] a_c = 0, pc_c = 0, a_d = 0, fl_a;
	logic [31:0] seed = 32'h1978;
	int failures = 0, num_checks = 0, kst = 0;
	flash_lock_and_write_guard dut_u (.i_core_clk(clk), .i_rst(rst), .i_sfr_wr(sfr_wr),
		.i_sfr_addr(sfr_a), .i_sfr_wdata(sfr_d), .o_psc_rdata(psc), .o_rst_rdata(rsr),
		.i_vmon_en(vmon), .i_vmon_rst_en(vmon_rst), .i_cpu_req(cpu_req), .i_cpu_op(op_c),
		.i_cpu_addr(a_c), .i_cpu_pc(pc_c), .i_cpu_wdata(wd_c), .i_dbg_req(dbg_req),
		.i_dbg_op(op_d), .i_dbg_addr(a_d), .i_dbg_wdata(wd_d), .i_dbg_device_erase(dev_erase),
		.o_fl_go(go), .o_fl_op(fl_op), .o_fl_addr(fl_a), .o_fl_wdata(fl_wd),
		.o_fl_mass_erase(mass), .i_fl_lock_byte(lock_b), .o_flash_error_device_reset(err),
		.o_irq_hold(irq));
	flash_array_model model_u (.i_core_clk(clk), .i_go(go), .i_op(fl_op), .i_addr(fl_a),
		.i_wdata(fl_wd), .i_mass(mass), .o_lock_byte(lock_b));
	// clock
	initial begin
		forever #20 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	function automatic logic lk(input logic [14:0] a);
		return ({2'b00, a[14:9]} < ~lock_act) || (a[14:9] == 6'h3f && lock_act != 8'hff);
	endfunction : lk
	task automatic chk_data(input logic [14:0] got, input logic [14:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_data
	task automatic chk_flag(input logic got, input logic exp);
		chk_data({14'h0, got}, {14'h0, exp});
	endtask : chk_flag
	task automatic end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic reset_dut();
		@(negedge clk);
		rst = 1;
		repeat (3) @(negedge clk);
		rst = 0;
		@(negedge clk);
		{lock_act, psc_m, kst} = {lock_m, 8'h00, 32'd0};
	endtask : reset_dut
	task automatic sfr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{sfr_wr, sfr_a, sfr_d} = {1'b1, a, d};
		@(negedge clk);
		sfr_wr = 0;
		if (a == 8'h8f) psc_m = d & 8'h03;
		if (a == 8'hb7)
			kst = (kst == 0 && d == 8'ha5) ? 1 : ((kst == 1 && d == 8'hf1) ? 2 : 0);
		// read images trail the register by one cycle
		@(negedge clk);
	endtask : sfr
	task automatic acc(input logic cpu, input logic [1:0] op, input logic [14:0] a, pc,
		input logic [7:0] d);
		logic ok;
		logic mod;
		ok = !lk(a) || (cpu && lk(pc));
		ok = ok && !(op != 2'h0 && a == 15'h7fff && lock_m != 8'hff);
		mod = cpu && op != 2'h0;
		if (mod) begin
			ok = ok && kst == 2 && psc_m[0] && vmon && vmon_rst && (op != 2'h2 || psc_m[1]);
			ok = ok && !(op == 2'h2 && a[14:9] == 6'h3f);
			kst = 0;
		end
		@(negedge clk);
		{cpu_req, dbg_req, op_c, op_d, a_c, a_d, pc_c, wd_c, wd_d} =
			{cpu, !cpu, op, op, a, a, pc, d, d};
		@(negedge clk);
		{cpu_req, dbg_req} = 2'b00;
		chk_flag(go, ok);
		chk_flag(irq, ok && mod);
		if (ok) begin
			chk_data(fl_a, a);
			chk_data({7'h00, fl_wd}, {7'h00, d});
			chk_data({13'h0000, fl_op}, {13'h0000, op});
		end
		@(negedge clk);
		chk_flag(err, cpu && !ok);
		if (ok && op == 2'h1 && a == 15'h7fff) lock_m = lock_m & d;
		repeat (8) @(negedge clk);
		chk_flag(irq, ok && mod);
		repeat (2) @(negedge clk);
		chk_flag(irq, 1'b0);
	endtask : acc
	// main sequence
	initial begin
		reset_dut();
		chk_data({7'h00, psc}, 15'h0000);
		sfr(8'h8f, 8'hff);
		chk_data({7'h00, psc}, 15'h0003);
		for (int i = 0; i < 4; i++) begin
			sfr(8'hb7, 8'ha5);
			sfr(8'hb7, 8'hf1);
			acc(1, 2'h1 + (i == 3), {2'b01, rnd(), 5'h00}, 15'h0000, rnd());
		end
		sfr(8'h8f, 8'h01);
		sfr(8'hb7, 8'ha5);
		sfr(8'hb7, 8'hf1);
		acc(1, 2'h1, 15'h7fff, 15'h0000, 8'hfd);
		acc(1, 2'h0, 15'h0200, 15'h0a00, 8'h00);
		reset_dut();
		acc(0, 2'h0, 15'h0200, 15'h0000, 8'h00);
		acc(0, 2'h0, 15'h0400, 15'h0000, 8'h00);
		acc(0, 2'h0, 15'h7ffe, 15'h0000, 8'h00);
		acc(0, 2'h1, 15'h7fff, 15'h0000, 8'hf0);
		acc(1, 2'h0, 15'h0200, 15'h0000, 8'h00);
		acc(1, 2'h0, 15'h0200, 15'h0a00, 8'h00);
		reset_dut();
		chk_flag(rsr[6], 1'b1);
		sfr(8'hef, 8'h02);
		chk_data({7'h00, rsr}, 15'h0002);
		vmon = 0;
		sfr(8'h8f, 8'h01);
		sfr(8'hb7, 8'ha5);
		sfr(8'hb7, 8'hf1);
		acc(1, 2'h1, 15'h2000, 15'h0000, rnd());
		vmon = 1;
		reset_dut();
		vmon_rst = 0;
		sfr(8'h8f, 8'h01);
		sfr(8'hb7, 8'ha5);
		sfr(8'hb7, 8'hf1);
		acc(1, 2'h1, 15'h2000, 15'h0000, rnd());
		vmon_rst = 1;
		@(negedge clk);
		dev_erase = 1;
		@(negedge clk);
		dev_erase = 0;
		chk_flag(mass, 1'b1);
		lock_m = 8'hff;
		reset_dut();
		acc(0, 2'h0, 15'h0000, 15'h0000, 8'h00);
		end_of_test();
	end
endmodule : test_flash_lock_and_write_guard
